/* File: logic/dmac_channel_ctrl.sv */
// Purpose: arm, abort, soft trigger, priority arbitration and count tracking for five channels
// Assumes: SFR port on mclk_in; CPU memory request from same-clock logic; triggers are pins
// Notes: data moves source to FIFO to destination; FIFO drain may stall the channel
`include "dmac_map.svh"
module dmac_channel_ctrl
    import dmac_pkg::*;
#(
    parameter int NCH = `DMAC_NUM_CH,
    parameter int FIFO_DEPTH = `DMAC_FIFO_DEPTH
) (
    // Clock, reset, enable
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // SFR port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // Channel configuration
    input dmac_cfg_t cfg_in [NCH],
    // External trigger pins, one per channel
    input wire logic [NCH-1:0] ext_trig_in,
    // Memory arbitration against the CPU
    input wire logic cpu_mem_req_in,
    output logic cpu_mem_grant_out,
    output logic dma_mem_grant_out,
    output logic [2:0] grant_chan_out,
    // Source read data for the granted channel
    input wire logic [15:0] src_data_in,
    // Destination side stream
    output logic dst_valid_out,
    output logic [18:0] dst_data_out,
    input wire logic dst_ready_in,
    // Status
    output logic [NCH-1:0] channel_done_flag_out,
    input wire logic [NCH-1:0] done_flag_clear_in,
    output logic [NCH-1:0] irq_out
);
    initial begin
        if (NCH < 1 || NCH > 5) begin
            $error("dmac_channel_ctrl: NCH must be 1 to 5");
        end
    end

    logic [NCH-1:0] channel_arm_bit;
    logic [NCH-1:0] channel_soft_trigger_bit;
    logic [NCH-1:0] pending;
    logic [NCH-1:0] done_flag;
    logic [NCH-1:0] trig_s1;
    logic [NCH-1:0] trig_s2;
    logic [NCH-1:0] trig_s3;
    logic [NCH-1:0] trig_rise;
    logic [NCH-1:0] done_evt;
    logic [NCH-1:0] lost_last;
    logic [7:0] remain [NCH];
    logic [NCH-1:0] len_loaded;
    dmac_state_t state;
    logic [2:0] cur;
    logic [2:0] next_cur;
    logic next_found;
    logic fifo_ready;
    logic want_dma;
    logic dma_wins;
    logic arm_wr;
    logic req_wr;
    logic abort_wr;
    logic [NCH-1:0] abort_sel;

    // Length from the first source byte
    function automatic logic [7:0] first_len(input dmac_cfg_t c, input logic [15:0] d);
        if (c.length_seven_bit_select) begin
            first_len = {1'b0, d[6:0]}; // RULE_02
        end else begin
            first_len = d[7:0]; // RULE_02
        end
    endfunction

    // Variable-length byte mode active
    function automatic logic is_variable_length_mode(input dmac_cfg_t c);
        is_variable_length_mode = (c.variable_length_mode != `DMAC_VARIABLE_LENGTH_MODE_FIXED)
            && (c.variable_length_mode != `DMAC_VARIABLE_LENGTH_MODE_FIXED2)
            && !c.transfer_unit_size; // RULE_02
    endfunction

    assign arm_wr = ce_in && sfr_wr_in && (sfr_addr_in == `DMAC_ARM_ADDR);
    assign req_wr = ce_in && sfr_wr_in && (sfr_addr_in == `DMAC_REQ_ADDR);
    assign abort_wr = arm_wr && sfr_wdata_in[`DMAC_ABORT_BIT];
    assign abort_sel = sfr_wdata_in[NCH-1:0]; // RULE_07

    // Trigger pins: three stages, rising edge when stage two is high and stage three is still low
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            trig_s1 <= '0;
            trig_s2 <= '0;
            trig_s3 <= '0;
        end else if (ce_in) begin
            trig_s1 <= ext_trig_in;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end

    // Hardware source ignored when select is zero; chained source is previous done
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            if (cfg_in[i].trigger_source_select == `DMAC_TRIG_NONE) begin
                trig_rise[i] = 1'b0; // RULE_13
            end else if (cfg_in[i].trigger_source_select == 5'h01) begin
                trig_rise[i] = (i == 0) ? done_evt[NCH-1] : done_evt[(i+NCH-1)%NCH];
            end else begin
                trig_rise[i] = trig_s2[i] && !trig_s3[i];
            end
        end
    end

    // Arm bits: software write, abort, and hardware clear at count
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_arm_bit <= '0;
        end else if (ce_in) begin
            for (int i = 0; i < NCH; i++) begin
                if (abort_wr && abort_sel[i]) begin
                    channel_arm_bit[i] <= 1'b0; // RULE_06 RULE_15
                end else if (arm_wr && !sfr_wdata_in[`DMAC_ABORT_BIT]) begin
                    channel_arm_bit[i] <= sfr_wdata_in[i];
                end else if (done_evt[i] && (cfg_in[i].mode == DMAC_MODE_SINGLE
                        || cfg_in[i].mode == DMAC_MODE_BLOCK)) begin
                    channel_arm_bit[i] <= 1'b0; // RULE_09
                end
            end
        end
    end

    // Soft trigger bits: write one sets, grant clears, set wins over clear
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_soft_trigger_bit <= '0;
        end else if (ce_in) begin
            for (int i = 0; i < NCH; i++) begin
                if (req_wr && sfr_wdata_in[i]) begin
                    channel_soft_trigger_bit[i] <= 1'b1; // RULE_10
                end else if (state == DMAC_ST_REQ && dma_wins && cur == 3'(i)) begin
                    channel_soft_trigger_bit[i] <= 1'b0; // RULE_11
                end
            end
        end
    end

    // Hardware trigger events latched until served; only armed channels keep them
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pending <= '0;
        end else if (ce_in) begin
            for (int i = 0; i < NCH; i++) begin
                if (!channel_arm_bit[i] || (abort_wr && abort_sel[i])) begin
                    pending[i] <= 1'b0; // RULE_08
                end else if (trig_rise[i]) begin
                    pending[i] <= 1'b1;
                end else if (state == DMAC_ST_REQ && dma_wins && cur == 3'(i)) begin
                    pending[i] <= 1'b0;
                end
            end
        end
    end

    // Lowest armed channel with a request is served next
    // Block modes keep asking after one trigger until the count is reached
    always_comb begin
        next_cur = '0;
        next_found = 1'b0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (channel_arm_bit[i] && (pending[i] || channel_soft_trigger_bit[i]
                    || (len_loaded[i] && (cfg_in[i].mode == DMAC_MODE_BLOCK
                    || cfg_in[i].mode == DMAC_MODE_REP_BLOCK)))) begin
                next_cur = 3'(i); // RULE_08
                next_found = 1'b1;
            end
        end
    end

    // Priority arbitration against the CPU
    assign want_dma = (state == DMAC_ST_REQ) && fifo_ready;
    always_comb begin
        case (cfg_in[cur].priority_level)
            DMAC_PRI_LOW: dma_wins = want_dma && !cpu_mem_req_in; // RULE_03
            DMAC_PRI_NORMAL: dma_wins = want_dma && (!cpu_mem_req_in || lost_last[cur]); // RULE_04
            DMAC_PRI_HIGH: dma_wins = want_dma; // RULE_05
            default: dma_wins = want_dma && !cpu_mem_req_in; // Reserved code treated as low
        endcase
    end
    assign dma_mem_grant_out = dma_wins;
    assign cpu_mem_grant_out = cpu_mem_req_in && !dma_wins;
    assign grant_chan_out = cur;

    // Remember a lost try so normal priority wins the next one
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lost_last <= '0;
        end else if (ce_in && want_dma) begin
            lost_last[cur] <= !dma_wins; // RULE_04
        end
    end

    // Channel sequencer
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= DMAC_ST_IDLE;
            cur <= '0;
        end else if (ce_in) begin
            case (state)
                DMAC_ST_IDLE: begin
                    if (next_found) begin
                        cur <= next_cur;
                        state <= DMAC_ST_REQ;
                    end
                end
                DMAC_ST_REQ: begin
                    if (abort_wr && abort_sel[cur]) begin
                        state <= DMAC_ST_IDLE; // RULE_06
                    end else if (!channel_arm_bit[cur]) begin
                        state <= DMAC_ST_IDLE; // RULE_08
                    end else if (dma_wins) begin
                        state <= DMAC_ST_XFER;
                    end
                end
                DMAC_ST_XFER: state <= DMAC_ST_IDLE;
                default: state <= DMAC_ST_IDLE;
            endcase
        end
    end

    // Remaining count per channel; first byte loads it in variable-length mode
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NCH; i++) begin
                remain[i] <= 8'h00;
            end
            len_loaded <= '0;
        end else if (ce_in) begin
            for (int i = 0; i < NCH; i++) begin
                if ((abort_wr && abort_sel[i]) || done_evt[i]) begin
                    len_loaded[i] <= 1'b0; // RULE_06
                end else if (state == DMAC_ST_XFER && cur == 3'(i)) begin
                    if (!len_loaded[i]) begin
                        remain[i] <= is_variable_length_mode(cfg_in[i]) ? first_len(cfg_in[i], src_data_in)
                            : cfg_in[i].fixed_len - 8'h01;
                        len_loaded[i] <= 1'b1;
                    end else begin
                        remain[i] <= remain[i] - 8'h01;
                    end
                end
            end
        end
    end

    // Count reached: last transfer of a loaded channel, a one-word fixed job, or a zero first byte in variable-length mode
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            done_evt[i] = ce_in && state == DMAC_ST_XFER && cur == 3'(i)
                && ((len_loaded[i] && remain[i] == 8'h01)
                || (!len_loaded[i] && !is_variable_length_mode(cfg_in[i]) && cfg_in[i].fixed_len == 8'h01)
                || (!len_loaded[i] && is_variable_length_mode(cfg_in[i])
                && first_len(cfg_in[i], src_data_in) == 8'h00));
        end
    end

    // Done flags: set wins over software clear
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            done_flag <= '0;
        end else if (ce_in) begin
            done_flag <= done_evt | (done_flag & ~done_flag_clear_in); // RULE_14
        end
    end
    assign channel_done_flag_out = done_flag;

    // Interrupt request gated per channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            irq_out[i] = done_flag[i] && cfg_in[i].channel_irq_enable; // RULE_01
        end
    end

    // Register readback; abort and unused bits read zero
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (ce_in) begin
            case (sfr_addr_in)
                `DMAC_ARM_ADDR: sfr_rdata_out <= 8'(channel_arm_bit); // RULE_15
                `DMAC_REQ_ADDR: sfr_rdata_out <= 8'(channel_soft_trigger_bit); // RULE_12
                default: sfr_rdata_out <= 8'h00;
            endcase
        end
    end

    // Data path buffer; a full buffer stalls the grant
    dmac_fifo #(.WIDTH(19), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .in_valid_in(state == DMAC_ST_XFER),
        .in_data_in({cur, src_data_in}),
        .in_ready_out(fifo_ready),
        .out_valid_out(dst_valid_out),
        .out_data_out(dst_data_out),
        .out_ready_in(dst_ready_in)
    );
endmodule

/* File: logic/dmac_map.svh */
// Purpose: register offsets, field positions, reset values and counts for the DMA channel block
// Assumes: 8-bit special-function-register port, five channels
// Notes: included by the package and the top module
// Contract
// RULE_01: Interrupt-enable set means an interrupt request when transfer count is reached.
// RULE_02: Variable length byte mode takes count from first byte, seven or eight bits.
// RULE_03: Low priority always lets a competing CPU access go first.
// RULE_04: Normal priority grants DMA over CPU on at least every second try.
// RULE_05: High priority always grants DMA first; software never writes encoding 11.
// RULE_06: Abort write cancels transfers and arm state of channels selected alongside.
// RULE_07: Software sets abort and exactly the arm bits of channels to abort.
// RULE_08: No transfer happens on a channel whose arm bit is clear.
// RULE_09: Non-repetitive modes clear the arm bit at transfer count; repeated keep it.
// RULE_10: Writing one to a soft trigger bit acts as one trigger; zero does nothing.
// RULE_11: Soft trigger bit clears when the channel is granted access.
// RULE_12: Five channels on bits 4..0; trigger register bits 7..5 read zero.
// RULE_13: Trigger select 00000 starts transfers only by the soft trigger bit.
// RULE_14: A per-channel done flag is set when the transfer count is reached.
// RULE_15: Abort bit always reads zero; aborted channels end with arm bits cleared.
`ifndef DMAC_MAP_SVH
`define DMAC_MAP_SVH
`define DMAC_ARM_ADDR 8'hd6
`define DMAC_REQ_ADDR 8'hd7
`define DMAC_ARM_RESET 8'h00
`define DMAC_REQ_RESET 8'h00
`define DMAC_ABORT_BIT 7
`define DMAC_NUM_CH 5
`define DMAC_FIFO_DEPTH 32
`define DMAC_VARIABLE_LENGTH_MODE_FIXED 3'b000
`define DMAC_VARIABLE_LENGTH_MODE_FIXED2 3'b111
`define DMAC_TRIG_NONE 5'h00
`endif

/* File: logic/dmac_pkg.sv */
// Purpose: types shared by the DMA channel block
// Assumes: constants come from dmac_map.svh
// Notes: one config struct per channel
`include "dmac_map.svh"
package dmac_pkg;
    typedef enum logic [1:0] {
        DMAC_PRI_LOW = 2'b00,
        DMAC_PRI_NORMAL = 2'b01,
        DMAC_PRI_HIGH = 2'b10,
        DMAC_PRI_RSVD = 2'b11
    } dmac_pri_t;

    typedef enum logic [1:0] {
        DMAC_MODE_SINGLE = 2'b00,
        DMAC_MODE_BLOCK = 2'b01,
        DMAC_MODE_REP_SINGLE = 2'b10,
        DMAC_MODE_REP_BLOCK = 2'b11
    } dmac_mode_t;

    // Per-channel configuration as read from the descriptor
    typedef struct packed {
        logic channel_irq_enable;
        logic length_seven_bit_select;
        logic [2:0] variable_length_mode;
        logic transfer_unit_size;
        logic [4:0] trigger_source_select;
        dmac_mode_t mode;
        dmac_pri_t priority_level;
        logic [7:0] fixed_len;
    } dmac_cfg_t;

    // Word moved through the data path
    typedef struct packed {
        logic [2:0] chan;
        logic [15:0] data;
    } dmac_word_t;

    typedef enum logic [1:0] {
        DMAC_ST_IDLE = 2'b00,
        DMAC_ST_REQ = 2'b01,
        DMAC_ST_XFER = 2'b10
    } dmac_state_t;
endpackage

/* File: logic/dmac_fifo.sv */
// Purpose: synchronous FIFO of flip-flops in the DMA data path
// Assumes: single clock, valid/ready on both sides
// Notes: full and empty come straight from the fill count
module dmac_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("dmac_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    // Honest flags from the fill count
    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign do_wr = ce_in && in_valid_in && in_ready_out;
    assign do_rd = ce_in && out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr];

    // Storage has no reset, only the pointers and count do
    always_ff @(posedge mclk_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // Pointers and count
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* File: verif/dmac_channel_ctrl_asserts.sv */
// Purpose: port-level checks on the DMA channel block
// Assumes: one clock, ce_in held high by the bench
// Notes: bound into dmac_channel_ctrl after the module
`include "dmac_map.svh"
module dmac_channel_ctrl_asserts
    import dmac_pkg::*;
#(
    parameter int NCH = 5,
    parameter int FIFO_DEPTH = 32
) (
    // Clock, reset, enable
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // SFR port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    // Configuration, pins and arbitration
    input dmac_cfg_t cfg_in [NCH],
    input wire logic [NCH-1:0] ext_trig_in,
    input wire logic cpu_mem_req_in,
    input wire logic cpu_mem_grant_out,
    input wire logic dma_mem_grant_out,
    input wire logic [2:0] grant_chan_out,
    input wire logic [15:0] src_data_in,
    // Stream and status
    input wire logic dst_valid_out,
    input wire logic [18:0] dst_data_out,
    input wire logic dst_ready_in,
    input wire logic [NCH-1:0] channel_done_flag_out,
    input wire logic [NCH-1:0] done_flag_clear_in,
    input wire logic [NCH-1:0] irq_out
);
    logic [NCH-1:0] irq_en;

    // Gather enables so the irq check is one vector compare
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            irq_en[i] = cfg_in[i].channel_irq_enable;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_irq_flag_mask: assert property (irq_out == (channel_done_flag_out & irq_en))
        else $error("irq does not follow flag and enable");
    a_low_prio_defers: assert property (
        (dma_mem_grant_out && cpu_mem_req_in) |->
        cfg_in[grant_chan_out].priority_level inside {DMAC_PRI_NORMAL, DMAC_PRI_HIGH})
        else $error("low priority channel went ahead of the CPU");
    a_cpu_grant_ok: assert property (
        cpu_mem_grant_out |-> (cpu_mem_req_in && !dma_mem_grant_out))
        else $error("CPU grant clashes with DMA grant");
    a_abort_clears_arm: assert property (
        (ce_in && sfr_wr_in && sfr_addr_in == `DMAC_ARM_ADDR && sfr_wdata_in[7])
        ##1 (!sfr_wr_in && sfr_addr_in == `DMAC_ARM_ADDR)
        |=> (sfr_rdata_out & ($past(sfr_wdata_in, 2) | 8'h80)) == 8'h00)
        else $error("aborted channels still armed");
    a_arm_top_zero: assert property (
        $past(sfr_addr_in) == `DMAC_ARM_ADDR |-> sfr_rdata_out[7:5] == 3'b000)
        else $error("arm register upper bits not zero");
    a_req_top_zero: assert property (
        $past(sfr_addr_in) == `DMAC_REQ_ADDR |-> sfr_rdata_out[7:5] == 3'b000)
        else $error("trigger register upper bits not zero");
    a_unmapped_zero: assert property (
        !($past(sfr_addr_in) inside {`DMAC_ARM_ADDR, `DMAC_REQ_ADDR}) |-> sfr_rdata_out == 8'h00)
        else $error("unmapped address reads nonzero");
    a_flag_sticky: assert property (
        ($past(channel_done_flag_out) & ~channel_done_flag_out & ~$past(done_flag_clear_in)) == '0)
        else $error("done flag dropped without clear");
    a_flag_after_xfer: assert property (
        |(channel_done_flag_out & ~$past(channel_done_flag_out)) |-> $past(dma_mem_grant_out, 2))
        else $error("done flag set without a transfer");
endmodule

bind dmac_channel_ctrl dmac_channel_ctrl_asserts #(.NCH(NCH), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);

/* File: verif/dmac_cpu_model.sv */
// Purpose: CPU core competing with the DMA for the memory bus
// Assumes: same clock as the DMA block
// Notes: gap_in makes a slow CPU that idles a cycle after each access
module dmac_cpu_model (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Bench control
    input wire logic busy_in,
    input wire logic gap_in,
    // Memory bus
    input wire logic grant_in,
    output logic req_out
);
    // Request is held until granted, never withdrawn early
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            req_out <= 1'b0;
        end else if (req_out && grant_in) begin
            req_out <= busy_in && !gap_in;
        end else if (!req_out) begin
            req_out <= busy_in;
        end
    end
endmodule

/* File: verif/test_dmac_channel_ctrl.sv */
// Purpose: self-checking bench for the DMA channel block
// Assumes: ce_in held high; source data driven by the bench
// Notes: CPU model supplies competing memory requests
`include "dmac_map.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module test_dmac_channel_ctrl
    import dmac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] sfr_addr_in = 8'h00;
    logic sfr_wr_in = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [7:0] sfr_rdata_out;
    dmac_cfg_t cfg [5] = '{default: '0};
    logic [4:0] ext_trig_in = 5'h00;
    logic cpu_mem_req_in, cpu_mem_grant_out, dma_mem_grant_out, dst_valid_out;
    logic [2:0] grant_chan_out;
    logic [15:0] src_data_in = 16'h5a3c;
    logic [18:0] dst_data_out;
    logic [18:0] last_dst = '0;
    logic dst_ready_in = 1'b1;
    logic [4:0] channel_done_flag_out, irq_out;
    logic [4:0] done_flag_clear_in = 5'h00;
    logic busy = 1'b0;
    logic gap = 1'b0;
    int failures = 0;
    int checks = 0;
    int grants = 0;
    int pops = 0;

    dmac_channel_ctrl dut (.ce_in(1'b1), .cfg_in(cfg), .*);
    dmac_cpu_model cpu (.mclk_in(mclk_in), .rst_in(rst_in), .busy_in(busy), .gap_in(gap),
        .grant_in(cpu_mem_grant_out), .req_out(cpu_mem_req_in));

    // 25 MHz clock
    always #20 mclk_in = ~mclk_in;

    // Tally grants and accepted stream words
    always @(posedge mclk_in) begin
        if (dma_mem_grant_out === 1'b1) grants <= grants + 1;
        if (dst_valid_out === 1'b1 && dst_ready_in === 1'b1) begin
            pops <= pops + 1;
            last_dst <= dst_data_out;
        end
    end

    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'b1;
        @(posedge mclk_in);
        sfr_wr_in <= 1'b0;
    endtask

    task automatic sfr_check(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_in);
        sfr_addr_in <= a;
        @(posedge mclk_in);
        #1 `CHK(sfr_rdata_out, e)
    endtask

    // Bounded wait for the flag with the FIFO drained
    task automatic wait_flag(input int ch);
        int n = 0;
        while (channel_done_flag_out[ch] !== 1'b1 || pops != grants) begin
            @(posedge mclk_in);
            n++;
            if (n > 2000) begin
                failures++;
                $display("ERROR %0t done flag timeout", $time);
                close_out();
            end
        end
    endtask

    task automatic clear_flag(input int ch);
        @(posedge mclk_in);
        done_flag_clear_in <= 5'(1 << ch);
        @(posedge mclk_in);
        done_flag_clear_in <= 5'h00;
    endtask

    function automatic dmac_cfg_t mk(input dmac_pri_t p, input dmac_mode_t m, input logic ie);
        mk = '0;
        mk.channel_irq_enable = ie;
        mk.mode = m;
        mk.priority_level = p;
        mk.fixed_len = 8'h01;
    endfunction

    task automatic t_reset();
        sfr_check(`DMAC_ARM_ADDR, `DMAC_ARM_RESET);
        sfr_check(`DMAC_REQ_ADDR, `DMAC_REQ_RESET);
        sfr_check(8'hd5, 8'h00);
        $display("reset values done");
    endtask

    // Disarmed request waits; pin trigger ignored with select zero
    task automatic t_gate();
        int g;
        cfg[1] <= mk(DMAC_PRI_LOW, DMAC_MODE_SINGLE, 1'b0);
        sfr_write(`DMAC_ARM_ADDR, 8'h04);
        sfr_write(`DMAC_REQ_ADDR, 8'h02);
        g = grants;
        ext_trig_in <= 5'h04;
        repeat (4) @(posedge mclk_in);
        ext_trig_in <= 5'h00;
        repeat (20) @(posedge mclk_in);
        `CHK(grants - g, 0)
        sfr_check(`DMAC_REQ_ADDR, 8'h02);
        sfr_write(`DMAC_ARM_ADDR, 8'h02);
        wait_flag(1);
        `CHK(last_dst, {3'd1, src_data_in})
        `CHK(irq_out[1], 1'b0)
        sfr_check(`DMAC_REQ_ADDR, 8'h00);
        sfr_check(`DMAC_ARM_ADDR, 8'h00);
        clear_flag(1);
        $display("arm gating done");
    endtask

    // Each priority against a busy CPU; in the high-priority run it idles a cycle after each access
    task automatic t_prio();
        int g;
        for (int i = 0; i < 3; i++) begin
            cfg[0] <= mk(dmac_pri_t'(i), DMAC_MODE_SINGLE, 1'b1);
            busy <= 1'b1;
            gap <= (i == 2);
            sfr_write(`DMAC_ARM_ADDR, 8'h01);
            sfr_write(`DMAC_REQ_ADDR, 8'h01);
            g = grants;
            repeat (24) @(posedge mclk_in);
            `CHK(grants - g, (i == 0) ? 0 : 1)
            busy <= 1'b0;
            wait_flag(0);
            `CHK(irq_out[0], 1'b1)
            clear_flag(0);
            #1 `CHK(channel_done_flag_out[0], 1'b0)
        end
        $display("priority done");
    endtask

    // Count from first byte; third run stalls the stream to fill the FIFO
    task automatic t_variable_length_mode();
        int n [3];
        int g;
        dmac_cfg_t c;
        c = mk(DMAC_PRI_HIGH, DMAC_MODE_BLOCK, 1'b0);
        c.variable_length_mode = 3'b001;
        for (int i = 0; i < 3; i++) begin
            c.length_seven_bit_select = (i == 0);
            cfg[3] <= c;
            src_data_in <= (i == 1) ? 16'h0003 : 16'h0083;
            dst_ready_in <= (i < 2);
            g = grants;
            sfr_write(`DMAC_ARM_ADDR, 8'h08);
            sfr_write(`DMAC_REQ_ADDR, 8'h08);
            if (i == 2) begin
                repeat (100) @(posedge mclk_in);
                `CHK(grants - g, `DMAC_FIFO_DEPTH)
                dst_ready_in <= 1'b1;
            end
            wait_flag(3);
            n[i] = grants - g;
            sfr_check(`DMAC_ARM_ADDR, 8'h00);
            clear_flag(3);
        end
        `CHK(n[0], n[1])
        `CHK(n[2], n[1] + 128)
        $display("variable length done");
    endtask

    // Repeated mode keeps arm; abort hits only the selected channels
    task automatic t_abort();
        int g;
        cfg[1] <= mk(DMAC_PRI_HIGH, DMAC_MODE_REP_SINGLE, 1'b1);
        sfr_write(`DMAC_ARM_ADDR, 8'h02);
        sfr_write(`DMAC_REQ_ADDR, 8'h02);
        wait_flag(1);
        sfr_check(`DMAC_ARM_ADDR, 8'h02);
        clear_flag(1);
        sfr_write(`DMAC_ARM_ADDR, 8'h82);
        sfr_check(`DMAC_ARM_ADDR, 8'h00);
        cfg[0] <= mk(DMAC_PRI_LOW, DMAC_MODE_SINGLE, 1'b1);
        busy <= 1'b1;
        sfr_write(`DMAC_ARM_ADDR, 8'h11);
        sfr_write(`DMAC_REQ_ADDR, 8'h01);
        sfr_write(`DMAC_ARM_ADDR, 8'h81);
        sfr_check(`DMAC_ARM_ADDR, 8'h10);
        busy <= 1'b0;
        g = grants;
        repeat (20) @(posedge mclk_in);
        `CHK(grants - g, 0)
        sfr_write(`DMAC_ARM_ADDR, 8'h90);
        sfr_check(`DMAC_ARM_ADDR, 8'h00);
        $display("abort done");
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset();
        t_gate();
        t_prio();
        t_variable_length_mode();
        t_abort();
        close_out();
    end
endmodule
